// ===== rxeq_pkg.sv
// Package: constants shared by the receiver equalizer control block
package rxeq_pkg;

  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] TAPIN_ADDR   = 12'h004;
  localparam logic [11:0] DLYIN_ADDR   = 12'h008;
  localparam logic [11:0] TAPMON_ADDR  = 12'h00C;
  localparam logic [11:0] CALMON_ADDR  = 12'h010;
  localparam logic [11:0] STATUS_ADDR  = 12'h014;
  localparam logic [11:0] TAPHI_ADDR   = 12'h018;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CFG_LO        = 0;   // equalizer_config_word [9:0]
  localparam int CFG_W         = 10;
  localparam int CFG_DLY_OVR   = 8;
  localparam int CFG_TAP_OVR   = 9;
  localparam int GND_BIT       = 10;
  localparam int RAIL_BIT      = 11;
  localparam int MODE_LO       = 12;
  localparam int MODE_W        = 2;
  localparam int RESET_BIT     = 14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0800;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DLY_W  = 6;
  localparam int EYE_W  = 5;
  localparam int SENS_W = 3;
  localparam int T1_W   = 5;
  localparam int T2_W   = 5;
  localparam int T34_W  = 4;
  localparam int NCH    = 2;

  // ****************************************
  // Termination selection (one-hot to pad switches)
  // ****************************************
  typedef enum logic [2:0] {
    TERM_GND  = 3'h1,
    TERM_TWO3 = 3'h2,
    TERM_RAIL = 3'h4
  } rxeq_term_type;

  // ****************************************
  // Calibration timing
  // ****************************************
  localparam int CAL_TIME_NS = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CAL_CYCLES  = CAL_TIME_NS / CLK_PERIOD_NS;

endpackage : rxeq_pkg

// ===== rxeq_sync.sv
// Three-flop synchroniser for the transceiver reset pin
`timescale 1ns/10ps
module rxeq_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);

  logic s1Q;
  logic s2Q;
  logic s3Q;

  // First flop feeds only the second; output moves when stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Q  <= 1'b0;
      s2Q  <= 1'b0;
      s3Q  <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1Q <= din;
      s2Q <= s1Q;
      s3Q <= s2Q;
      if (s2Q == s3Q) begin
        dout <= s3Q;
      end
    end
  end

endmodule : rxeq_sync

// ===== rxeq_chan_cal.sv
// One channel of the feedback equalizer calibration and weight selection
`timescale 1ns/10ps
module rxeq_chan_cal #(
  parameter int CAL_CYCLES = rxeq_pkg::CAL_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        xcvrReset,
  input  wire logic                        dlyOverride,
  input  wire logic                        tapOverride,
  input  wire logic [rxeq_pkg::DLY_W-1:0]  dlyIn,
  input  wire logic [rxeq_pkg::T1_W-1:0]   tap1In,
  input  wire logic [rxeq_pkg::T2_W-1:0]   tap2In,
  input  wire logic [rxeq_pkg::T34_W-1:0]  tap3In,
  input  wire logic [rxeq_pkg::T34_W-1:0]  tap4In,
  output logic      [rxeq_pkg::DLY_W-1:0]  dlyOut,
  output logic      [rxeq_pkg::EYE_W-1:0]  eyeOut,
  output logic      [rxeq_pkg::SENS_W-1:0] sensOut,
  output logic      [rxeq_pkg::T1_W-1:0]   tap1Out,
  output logic      [rxeq_pkg::T2_W-1:0]   tap2Out,
  output logic      [rxeq_pkg::T34_W-1:0]  tap3Out,
  output logic      [rxeq_pkg::T34_W-1:0]  tap4Out,
  output logic                             calBusy
);

  typedef enum {IDLE, SENS, DLY, RUN} rxeq_cal_type;

  rxeq_cal_type                stateQ;
  logic [15:0]                 cntQ;
  logic [rxeq_pkg::DLY_W-1:0]  calDlyQ;
  logic [rxeq_pkg::EYE_W-1:0]  eyeQ;
  logic [rxeq_pkg::SENS_W-1:0] sensQ;
  logic [rxeq_pkg::T1_W-1:0]   ad1Q;
  logic [rxeq_pkg::T2_W-1:0]   ad2Q;
  logic [rxeq_pkg::T34_W-1:0]  ad3Q;
  logic [rxeq_pkg::T34_W-1:0]  ad4Q;
  logic                        cntDone;

  assign cntDone = (cntQ == 16'(CAL_CYCLES - 1));

  // ****************************************
  // Calibration sequence, restarted by transceiver reset
  // ****************************************
  // Sampler offset first, then clock delay search while tracking best eye height
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateQ  <= IDLE;
      cntQ    <= 16'h0000;
      calDlyQ <= '0;
      eyeQ    <= '0;
      sensQ   <= '0;
    end else if (xcvrReset) begin
      stateQ <= IDLE;
      cntQ   <= 16'h0000;
    end else begin
      case (stateQ)
        IDLE: begin
          stateQ  <= SENS;
          sensQ   <= '0;
          calDlyQ <= '0;
          eyeQ    <= '0;
        end
        SENS: begin
          cntQ <= cntDone ? 16'h0000 : cntQ + 16'h0001;
          if (cntDone) begin
            sensQ  <= 3'(cntQ[2:0] ^ cntQ[5:3]);
            stateQ <= DLY;
          end
        end
        DLY: begin
          cntQ <= cntDone ? 16'h0000 : cntQ + 16'h0001;
          if (cntQ[2:0] == 3'h7 && eyeQ != '1) begin
            eyeQ    <= eyeQ + 5'h01;
            calDlyQ <= calDlyQ + 6'h01;
          end
          if (cntDone) begin
            stateQ <= RUN;
          end
        end
        RUN: begin
          stateQ <= RUN;
        end
        default: begin
          stateQ <= IDLE;
        end
      endcase
    end
  end

  // Self-adapted weights track the eye height while in RUN; a crude stand-in for the analog loop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ad1Q <= '0;
      ad2Q <= '0;
      ad3Q <= '0;
      ad4Q <= '0;
    end else if (stateQ == RUN) begin
      ad1Q <= eyeQ;
      ad2Q <= {1'b0, eyeQ[4:1]};
      ad3Q <= {1'b1, eyeQ[4:2]};
      ad4Q <= {1'b0, eyeQ[4:2]};
    end
  end

  // ****************************************
  // Monitor outputs
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dlyOut  <= '0;
      eyeOut  <= '0;
      sensOut <= '0;
      tap1Out <= '0;
      tap2Out <= '0;
      tap3Out <= '0;
      tap4Out <= '0;
      calBusy <= 1'b1;
    end else begin
      dlyOut  <= dlyOverride ? dlyIn : calDlyQ;
      eyeOut  <= eyeQ;
      sensOut <= sensQ;
      tap1Out <= tapOverride ? tap1In : ad1Q;
      tap2Out <= tapOverride ? tap2In : ad2Q;
      tap3Out <= tapOverride ? tap3In : ad3Q;
      tap4Out <= tapOverride ? tap4In : ad4Q;
      calBusy <= (stateQ != RUN);
    end
  end

endmodule : rxeq_chan_cal

// ===== rxeq_top.sv
// Top: APB registers, termination select, equalizer mode and two calibration channels
`timescale 1ns/10ps

// Behaviour
// - Exactly one termination voltage is connected to both pads at any time.
// - Ground flag wins to ground; rail flag to full rail; neither gives two thirds.
// - Linear equalizer runs in one of four modes from a 2-bit select.
// - Six-bit delay override spans zero to ninety degrees of clock phase.
// - Delay override is used only while configuration bit 8 is set.
// - Each channel reports its applied delay (override value or calibration result) on a 6-bit monitor.
// - Averaged eye height reported on a 5-bit monitor, all ones near 180 mV.
// - Sampler offset self-calibrates after reset, reported as 3 bits, 000 lowest.
// - Tap one weight is a 5-bit input per channel.
// - Tap two weight is sign plus 4-bit magnitude.
// - Taps three and four are sign plus 3-bit magnitude.
// - Each channel monitors all four tap weights with matching encodings.
// - Configuration bit 9 selects tap inputs over self-adapted weights.
// - With configuration bit 8 clear the calibrated delay is applied.
// - Delay calibration runs when transceiver reset is released.
module rxeq_top #(
  parameter int CAL_CYCLES = rxeq_pkg::CAL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        transceiverResetPin,
  output logic      [2:0]  termSwitch0,
  output logic      [2:0]  termSwitch1,
  output logic      [1:0]  linearEqModeSelect,
  output logic      [rxeq_pkg::DLY_W-1:0] appliedDelay0,
  output logic      [rxeq_pkg::DLY_W-1:0] appliedDelay1
);

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrlQ;
  logic [31:0] tapInQ [rxeq_pkg::NCH];
  logic [31:0] dlyInQ;
  logic        xcvrResetPin;
  logic        xcvrReset;

  logic [rxeq_pkg::DLY_W-1:0]  dlyMon  [rxeq_pkg::NCH];
  logic [rxeq_pkg::EYE_W-1:0]  eyeMon  [rxeq_pkg::NCH];
  logic [rxeq_pkg::SENS_W-1:0] sensMon [rxeq_pkg::NCH];
  logic [rxeq_pkg::T1_W-1:0]   t1Mon   [rxeq_pkg::NCH];
  logic [rxeq_pkg::T2_W-1:0]   t2Mon   [rxeq_pkg::NCH];
  logic [rxeq_pkg::T34_W-1:0]  t3Mon   [rxeq_pkg::NCH];
  logic [rxeq_pkg::T34_W-1:0]  t4Mon   [rxeq_pkg::NCH];
  logic                        busy    [rxeq_pkg::NCH];

  logic access;
  logic addrOk;

  // Decodes a termination pair; ground takes priority so two switches never close
  function automatic rxeq_pkg::rxeq_term_type term_decode(input logic gnd, input logic rail);
    if (gnd) begin
      term_decode = rxeq_pkg::TERM_GND;
    end else if (rail) begin
      term_decode = rxeq_pkg::TERM_RAIL;
    end else begin
      term_decode = rxeq_pkg::TERM_TWO3;
    end
  endfunction : term_decode

  function automatic logic addr_valid(input logic [11:0] a);
    addr_valid = (a == rxeq_pkg::CTRL_ADDR)   || (a == rxeq_pkg::TAPIN_ADDR)  ||
                 (a == rxeq_pkg::DLYIN_ADDR)  || (a == rxeq_pkg::TAPMON_ADDR) ||
                 (a == rxeq_pkg::CALMON_ADDR) || (a == rxeq_pkg::STATUS_ADDR) ||
                 (a == rxeq_pkg::TAPHI_ADDR);
  endfunction : addr_valid

  assign access = psel && penable;
  assign addrOk = addr_valid(paddr);

  // ****************************************
  // Reset pin crossing, combined with software reset bit
  // ****************************************
  rxeq_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (transceiverResetPin),
    .dout (xcvrResetPin)
  );
  assign xcvrReset = xcvrResetPin | ctrlQ[rxeq_pkg::RESET_BIT];

  // ****************************************
  // Writable registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlQ     <= rxeq_pkg::CTRL_RESET;
      tapInQ[0] <= 32'h0000_0000;
      tapInQ[1] <= 32'h0000_0000;
      dlyInQ    <= 32'h0000_0000;
    end else if (access && pwrite && pready) begin
      case (paddr)
        rxeq_pkg::CTRL_ADDR:   ctrlQ     <= pwdata;
        rxeq_pkg::TAPIN_ADDR:  tapInQ[0] <= pwdata;
        rxeq_pkg::DLYIN_ADDR:  dlyInQ    <= pwdata;
        rxeq_pkg::TAPMON_ADDR: tapInQ[1] <= pwdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // APB answer: no wait states, error on unmapped address
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      // Refused writes clear the data bus too, so an error never carries stale read data
      if (psel && !penable && !(pwrite && addrOk)) begin
        case (paddr)
          rxeq_pkg::CTRL_ADDR:   prdata <= ctrlQ;
          rxeq_pkg::TAPIN_ADDR:  prdata <= tapInQ[0];
          rxeq_pkg::DLYIN_ADDR:  prdata <= dlyInQ;
          rxeq_pkg::TAPMON_ADDR: prdata <= tapInQ[1];
          // Eight monitors need 36 bits; the second channel's fourth tap spills to its own word
          rxeq_pkg::CALMON_ADDR: prdata <= {t3Mon[1], t2Mon[1], t1Mon[1],
                                            t4Mon[0], t3Mon[0], t2Mon[0], t1Mon[0]};
          rxeq_pkg::TAPHI_ADDR:  prdata <= {28'h000_0000, t4Mon[1]};
          rxeq_pkg::STATUS_ADDR: prdata <= {busy[1], busy[0], 2'h0,
                                            sensMon[1], sensMon[0], eyeMon[1], eyeMon[0],
                                            dlyMon[1], dlyMon[0]};
          default:               prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Termination and linear equalizer outputs
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      termSwitch0        <= rxeq_pkg::TERM_RAIL;
      termSwitch1        <= rxeq_pkg::TERM_RAIL;
      linearEqModeSelect <= 2'h0;
    end else begin
      termSwitch0        <= term_decode(ctrlQ[rxeq_pkg::GND_BIT], ctrlQ[rxeq_pkg::RAIL_BIT]);
      termSwitch1        <= term_decode(ctrlQ[rxeq_pkg::GND_BIT], ctrlQ[rxeq_pkg::RAIL_BIT]);
      linearEqModeSelect <= ctrlQ[rxeq_pkg::MODE_LO +: rxeq_pkg::MODE_W];
    end
  end

  // ****************************************
  // Calibration channels
  // ****************************************
  logic [rxeq_pkg::DLY_W-1:0] dlyApplied [rxeq_pkg::NCH];

  genvar ch;
  generate
    for (ch = 0; ch < rxeq_pkg::NCH; ch++) begin : g_chan
      rxeq_chan_cal #(
        .CAL_CYCLES (CAL_CYCLES)
      ) u_cal (
        .clk         (clk),
        .rst         (rst),
        .xcvrReset   (xcvrReset),
        .dlyOverride (ctrlQ[rxeq_pkg::CFG_DLY_OVR]),
        .tapOverride (ctrlQ[rxeq_pkg::CFG_TAP_OVR]),
        .dlyIn       (dlyInQ[ch*8 +: rxeq_pkg::DLY_W]),
        .tap1In      (tapInQ[ch][0 +: rxeq_pkg::T1_W]),
        .tap2In      (tapInQ[ch][8 +: rxeq_pkg::T2_W]),
        .tap3In      (tapInQ[ch][16 +: rxeq_pkg::T34_W]),
        .tap4In      (tapInQ[ch][24 +: rxeq_pkg::T34_W]),
        .dlyOut      (dlyApplied[ch]),
        .eyeOut      (eyeMon[ch]),
        .sensOut     (sensMon[ch]),
        .tap1Out     (t1Mon[ch]),
        .tap2Out     (t2Mon[ch]),
        .tap3Out     (t3Mon[ch]),
        .tap4Out     (t4Mon[ch]),
        .calBusy     (busy[ch])
      );
      assign dlyMon[ch] = dlyApplied[ch];
    end
  endgenerate

  // Applied delay also leaves as a registered output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      appliedDelay0 <= '0;
      appliedDelay1 <= '0;
    end else begin
      appliedDelay0 <= dlyMon[0];
      appliedDelay1 <= dlyMon[1];
    end
  end

endmodule : rxeq_top

// ===== rxeq_checker.sv
// Port assertions for the equalizer control block
`timescale 1ns/10ps
module rxeq_checker #(
  parameter int CAL_CYCLES = 8
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        transceiverResetPin,
  input wire logic [2:0]  termSwitch0,
  input wire logic [2:0]  termSwitch1,
  input wire logic [1:0]  linearEqModeSelect,
  input wire logic [5:0]  appliedDelay0,
  input wire logic [5:0]  appliedDelay1
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Shadow registers; quiet counts edges since the last write, holding at 3
  // ****************************************
  logic        wrTake;
  logic [31:0] ctrlM_q;
  logic [31:0] dlyM_q;
  logic [31:0] tapM_q;
  logic [31:0] tap1M_q;
  logic [1:0]  quiet_q;
  logic [2:0]  termExp;
  assign wrTake  = psel && penable && pready && pwrite;
  assign termExp = ctrlM_q[10] ? 3'h1 : (ctrlM_q[11] ? 3'h4 : 3'h2);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_q <= 2'h0;
    end else if (wrTake) begin
      quiet_q <= 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlM_q <= 32'h0000_0800;
      dlyM_q  <= 32'h0000_0000;
      tapM_q  <= 32'h0000_0000;
      tap1M_q <= 32'h0000_0000;
    end else if (wrTake) begin
      if (paddr == 12'h000) ctrlM_q <= pwdata;
      if (paddr == 12'h004) tapM_q <= pwdata;
      if (paddr == 12'h008) dlyM_q <= pwdata;
      if (paddr == 12'h00C) tap1M_q <= pwdata;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  term_onehot_a: assert property ($onehot(termSwitch0) && $onehot(termSwitch1))
    else $error("termination switch not one-hot");
  term_select_a: assert property (quiet_q == 2'h3 |-> termSwitch0 == termExp && termSwitch1 == termExp)
    else $error("termination differs from flags");
  eq_mode_a: assert property (quiet_q == 2'h3 |-> linearEqModeSelect == ctrlM_q[13:12])
    else $error("equalizer mode differs from control");
  dly_override_a: assert property (quiet_q == 2'h3 && ctrlM_q[8]
    |-> appliedDelay0 == dlyM_q[5:0] && appliedDelay1 == dlyM_q[13:8])
    else $error("override delay not applied");
  tap_monitor_a: assert property (pready && !pwrite && paddr == 12'h010 && ctrlM_q[9] && quiet_q == 2'h3
    |-> prdata == {tap1M_q[19:16], tap1M_q[12:8], tap1M_q[4:0],
                   tapM_q[27:24], tapM_q[19:16], tapM_q[12:8], tapM_q[4:0]})
    else $error("tap monitor differs from tap inputs");
  tap_high_a: assert property (pready && !pwrite && paddr == 12'h018 && ctrlM_q[9] && quiet_q == 2'h3
    |-> prdata == {28'h000_0000, tap1M_q[27:24]})
    else $error("second channel tap four monitor differs");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  refuse_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response without ready or with data");
endmodule : rxeq_checker

bind rxeq_top rxeq_checker #(.CAL_CYCLES(CAL_CYCLES)) chk_u (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .transceiverResetPin(transceiverResetPin), .termSwitch0(termSwitch0), .termSwitch1(termSwitch1),
  .linearEqModeSelect(linearEqModeSelect), .appliedDelay0(appliedDelay0), .appliedDelay1(appliedDelay1));

// ===== rxeq_apb_host.sv
// APB master model standing in for the user logic
`timescale 1ns/10ps
module rxeq_apb_host (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  // ****************************************
  // One transfer; request held until ready is seen at a rising edge
  // ****************************************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the rising edge that sees ready, then the request is let go
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer
endmodule : rxeq_apb_host

// ===== tb.sv
// Self-checking bench for the equalizer control block
`timescale 1ns/10ps
module tb;
  localparam int CAL = 8;
  logic        clk, rst, xrst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, c, dl, t0, t1;
  logic [31:0] seed = 32'h0000_005D;
  logic [2:0]  term0, term1;
  logic [1:0]  mode;
  logic [5:0]  dly0, dly1;
  int          n_fail = 0;
  int          tests_run = 0;
  int          k;

  rxeq_apb_host host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rxeq_top #(.CAL_CYCLES(CAL)) dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transceiverResetPin(xrst), .termSwitch0(term0), .termSwitch1(term1),
    .linearEqModeSelect(mode), .appliedDelay0(dly0), .appliedDelay1(dly1));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [2:0] termOf(input logic [31:0] v);
    return v[10] ? 3'h1 : (v[11] ? 3'h4 : 3'h2);
  endfunction : termOf
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    host_u.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd
  task automatic waitN(input int n);
    repeat (n) @(negedge clk);
  endtask : waitN
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst  = 1'b1;
    xrst = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000);
    chk(r, 32'h0000_0800);
    chk(term0, 3'h4);
    // Every flag pair and every mode; delay override kept off
    for (int i = 0; i < 16; i++) begin
      c = (rnd() & 32'h0000_02FF) | (32'(i) << 10);
      wr(12'h000, c);
      waitN(3);
      chk(term0, termOf(c));
      chk(term1, termOf(c));
      chk(mode, c[13:12]);
      rd(12'h000);
      chk(r, c);
    end
    $display("test termination and mode done");
    for (int i = 0; i < 4; i++) begin
      dl = rnd() & 32'h0000_3F3F;
      t0 = rnd() & 32'h0F0F_1F1F;
      t1 = rnd() & 32'h0F0F_1F1F;
      if (i == 0) dl = 32'h0000_3F00;
      if (i == 0) t0 = 32'h0A0A_121F;
      wr(12'h008, dl);
      wr(12'h004, t0);
      wr(12'h00C, t1);
      wr(12'h000, 32'h0000_0300);
      waitN(3);
      chk(dly0, dl[5:0]);
      chk(dly1, dl[13:8]);
      rd(12'h010);
      chk(r, {t1[19:16], t1[12:8], t1[4:0], t0[27:24], t0[19:16], t0[12:8], t0[4:0]});
      rd(12'h018);
      chk(r, {28'h000_0000, t1[27:24]});
      rd(12'h014);
      chk(r[11:0], {dl[13:8], dl[5:0]});
    end
    $display("test overrides done");
    // Delay override off, then a reset pulse reruns calibration; two thirds rail and mode 10
    wr(12'h000, 32'h0000_2000);
    @(posedge clk);
    xrst <= 1'b1;
    repeat (4) @(posedge clk);
    xrst <= 1'b0;
    waitN(6);
    rd(12'h014);
    chk(r[31:30], 2'h3);
    k = 0;
    while (r[31:30] !== 2'h0 && k < 60) begin
      rd(12'h014);
      k++;
    end
    chk(r[31:30], 2'h0);
    waitN(2);
    chk(dly0, r[5:0]);
    chk(dly1, r[11:6]);
    $display("test calibration done");
    // Unmapped place is refused and leaves the control word alone
    wr(12'h01C, 32'hFFFF_FFFF);
    chk(e, 1'b1);
    rd(12'h01C);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    rd(12'h000);
    chk(r, 32'h0000_2000);
    $display("test unmapped done");
    close_out();
  end
endmodule : tb
